// ===== core/stk_pkg.sv
// Register map, field layout and reset values of the system tick timer
package stk_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL_STATUS = 8'h00;
  localparam logic [7:0] OFF_RELOAD      = 8'h04;
  localparam logic [7:0] OFF_CURRENT     = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h10;
  localparam int unsigned ADDR_W         = 8;

  // Control and status fields
  localparam int unsigned BIT_ENABLE     = 0;
  localparam int unsigned BIT_CLK_CORE   = 2;
  localparam int unsigned BIT_ZERO_FLAG  = 16;

  // Interrupt status and mask fields
  localparam int unsigned BIT_IRQ_TICK   = 0;
  localparam int unsigned IRQ_W          = 1;

  // Count field width and reset values
  localparam int unsigned COUNT_W        = 24;
  localparam logic [23:0] RELOAD_RST     = 24'h000000;
  localparam logic [23:0] COUNT_RST      = 24'h000000;
  localparam logic        ENABLE_RST     = 1'b0;
  localparam logic [0:0]  IRQ_MASK_RST   = 1'h0;

  // AXI response codes
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : stk_pkg

// ===== core/stk_top.sv
// System tick timer: 24-bit down counter with reload, current count and AXI4-Lite registers
// Functional notes
// - Reload field is bits 23:0; copied into the count when the count is zero while the counter is counting.
// - Bits 31:24 of reload and count are reserved; read zero, writes ignored.
// - A count read returns the live counter value at the read handshake.
// - Any write to the current count register clears the count to zero.
// - A write to the current count register also clears the zero-reached flag.
// - No calibration register exists; its offset is unmapped.
// - Enabled counter decrements each clock, reloads after zero; period is reload plus one.
// - Reaching zero sets the zero-reached flag; reading control and status clears it.
// - Reload of zero stops the counter at the next wrap.
// - While the core is halted for debug the counter holds.
`timescale 1ns/1ns
module stk_top #(
  parameter int unsigned CNT_W = stk_pkg::COUNT_W
) (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // Core debug state
  input  wire logic                       debug_halt,
  // AXI4-Lite write address
  input  wire logic [stk_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [stk_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Interrupt and tick event
  output logic                            irq,
  output logic                            tick_pulse
);

  // Byte-lane merge of new write data into an existing register value
  function automatic logic [31:0] lane_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // Address decode shared by both channels
  function automatic logic is_mapped(input logic [stk_pkg::ADDR_W-1:0] a);
    return (a == stk_pkg::OFF_CTRL_STATUS) || (a == stk_pkg::OFF_RELOAD) ||
           (a == stk_pkg::OFF_CURRENT) || (a == stk_pkg::OFF_IRQ_STATUS) ||
           (a == stk_pkg::OFF_IRQ_MASK);
  endfunction : is_mapped

  // The protection inputs are ignored: every register is open to any master

  // Timer state
  logic [CNT_W-1:0]             reload_val;
  logic [CNT_W-1:0]             count;
  logic                         enable;
  logic                         zero_flag;
  logic [stk_pkg::IRQ_W-1:0]    irq_status;
  logic [stk_pkg::IRQ_W-1:0]    irq_mask;

  // Write channel holding state
  logic                         aw_got;
  logic                         w_got;
  logic [stk_pkg::ADDR_W-1:0]   wr_addr;
  logic [31:0]                  wr_data;
  logic [3:0]                   wr_strb;
  logic                         next_aw_got;
  logic                         next_w_got;
  logic                         do_wr;
  logic                         rd_take;

  // Decoded write strobes and timer events
  logic                         wr_ctrl;
  logic                         wr_reload;
  logic                         wr_current;
  logic                         wr_status;
  logic                         wr_mask;
  logic                         rd_ctrl;
  logic                         counting;
  logic                         hit_zero;
  logic [31:0]                  rd_value;
  logic [31:0]                  ctrl_word;
  logic [31:0]                  mask_word;
  logic [31:0]                  reload_word;

  // Write executes once address and data are both held and no response is pending
  assign do_wr      = aw_got && w_got && !s_axi_bvalid;
  assign rd_take    = s_axi_arvalid && s_axi_arready;
  assign wr_ctrl    = do_wr && (wr_addr == stk_pkg::OFF_CTRL_STATUS);
  assign wr_reload  = do_wr && (wr_addr == stk_pkg::OFF_RELOAD);
  assign wr_current = do_wr && (wr_addr == stk_pkg::OFF_CURRENT);
  assign wr_status  = do_wr && (wr_addr == stk_pkg::OFF_IRQ_STATUS);
  assign wr_mask    = do_wr && (wr_addr == stk_pkg::OFF_IRQ_MASK);
  // A bus read of control and status, or a count write, clears the zero-reached flag
  assign rd_ctrl    = rd_take && (s_axi_araddr == stk_pkg::OFF_CTRL_STATUS);

  // Counter advances only when enabled and the core is running
  assign counting = enable && !debug_halt;
  // The tick fires on the step from one to zero, so a zero reload never fires
  assign hit_zero = counting && !wr_current && (count == CNT_W'(1));

  always_comb begin
    next_aw_got = aw_got;
    next_w_got  = w_got;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
    end else if (do_wr) begin
      next_aw_got = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
    end else if (do_wr) begin
      next_w_got = 1'b0;
    end
  end

  // Address and data are taken independently, one of each held at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      wr_addr       <= '0;
      wr_data       <= 32'h00000000;
      wr_strb       <= 4'h0;
    end else begin
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      s_axi_awready <= !next_aw_got;
      s_axi_wready  <= !next_w_got;
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
    end
  end

  // Write response handshake; only one response is ever outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Response code; unmapped offsets, the calibration slot among them, answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= stk_pkg::RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bresp <= is_mapped(wr_addr) ? stk_pkg::RESP_OKAY : stk_pkg::RESP_SLVERR;
    end
  end

  assign ctrl_word   = lane_merge({31'h00000000, enable}, wr_data, wr_strb);
  assign mask_word   = lane_merge({{(32-stk_pkg::IRQ_W){1'b0}}, irq_mask}, wr_data, wr_strb);
  assign reload_word = lane_merge({{(32-CNT_W){1'b0}}, reload_val}, wr_data, wr_strb);

  // Software configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable     <= stk_pkg::ENABLE_RST;
      reload_val <= CNT_W'(stk_pkg::RELOAD_RST);
      irq_mask   <= stk_pkg::IRQ_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        enable <= ctrl_word[stk_pkg::BIT_ENABLE];
      end
      // Reserved upper bits never reach the reload field
      if (wr_reload) begin
        reload_val <= reload_word[CNT_W-1:0];
      end
      if (wr_mask) begin
        irq_mask <= mask_word[stk_pkg::IRQ_W-1:0];
      end
    end
  end

  // Down counter
  // A count write outranks counting and, through hit_zero, produces no tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= CNT_W'(stk_pkg::COUNT_RST);
    end else if (wr_current) begin
      count <= '0;
    end else if (counting) begin
      if (count == '0) begin
        // A zero reload leaves the count parked at zero
        count <= reload_val;
      end else begin
        count <= count - CNT_W'(1);
      end
    end
  end

  // Zero-reached flag; a new zero event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_flag <= 1'b0;
    end else if (hit_zero) begin
      zero_flag <= 1'b1;
    end else if (rd_ctrl || wr_current) begin
      zero_flag <= 1'b0;
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else if (hit_zero) begin
      irq_status[stk_pkg::BIT_IRQ_TICK] <= 1'b1;
    end else if (wr_status && wr_strb[0] && wr_data[stk_pkg::BIT_IRQ_TICK]) begin
      irq_status[stk_pkg::BIT_IRQ_TICK] <= 1'b0;
    end
  end

  // Registered outputs: irq lags the status by one cycle, tick_pulse rises with the status, traded for clean flop outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq        <= 1'b0;
      tick_pulse <= 1'b0;
    end else begin
      irq        <= |(irq_status & irq_mask);
      tick_pulse <= hit_zero;
    end
  end

  // Read mux; the count is sampled live with no holding copy
  // Reserved bits of every register read as zero
  always_comb begin
    rd_value = 32'h00000000;
    case (s_axi_araddr)
      stk_pkg::OFF_CTRL_STATUS: begin
        rd_value[stk_pkg::BIT_ENABLE]    = enable;
        rd_value[stk_pkg::BIT_CLK_CORE]  = 1'b1;
        rd_value[stk_pkg::BIT_ZERO_FLAG] = zero_flag;
      end
      stk_pkg::OFF_RELOAD:     rd_value[CNT_W-1:0] = reload_val;
      stk_pkg::OFF_CURRENT:    rd_value[CNT_W-1:0] = count;
      stk_pkg::OFF_IRQ_STATUS: rd_value[stk_pkg::IRQ_W-1:0] = irq_status;
      stk_pkg::OFF_IRQ_MASK:   rd_value[stk_pkg::IRQ_W-1:0] = irq_mask;
      default:                 rd_value = 32'h00000000;
    endcase
  end

  // Read handshake: one read in flight, address refused while data waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Read payload, registered at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= stk_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rdata <= rd_value;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? stk_pkg::RESP_OKAY : stk_pkg::RESP_SLVERR;
    end
  end

endmodule : stk_top

// ===== tb/stk_checker.sv
// Bus handshake and tick timing checker for the system tick timer top
`timescale 1ns/1ns
module stk_checker (
  // Clock, reset and halt
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        debug_halt,
  // Write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Tick event
  input wire logic        tick_pulse
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("late write response");
  a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address accepted");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("late read");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read data not released");
  a_unmapped_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
    |=> s_axi_rresp == stk_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_count_upper: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == stk_pkg::OFF_CURRENT
    |=> s_axi_rdata[31:24] == 8'h00) else $error("count upper bits set");
  a_halt_no_tick: assert property (debug_halt [*3] |-> !tick_pulse)
    else $error("tick while halted");
  a_tick_single: assert property (tick_pulse |=> !tick_pulse)
    else $error("tick pulse too long");
endmodule : stk_checker

bind stk_top stk_checker u_chk (.aclk(aclk), .aresetn(aresetn), .debug_halt(debug_halt),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .tick_pulse(tick_pulse));

// ===== tb/stk_top_tb.sv
// Self-checking bench of the system tick timer registers and counter
`timescale 1ns/1ns
module stk_top_tb;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] r;} stk_row_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        halt = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bred = 1'b0, arv = 1'b0, rred = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic        awr, wr, bv, arr, rv, irq, tick;
  logic [1:0]  br, rr;
  logic [31:0] rd, v1, v2;
  int          n_fail = 0, checks_done = 0, cyc = 0, n = 0;
  // Reset values, reserved bits, unmapped offset, then setup for the counter tests
  stk_row_t    rows [12] = '{'{1'b0, 8'h00, 32'h4, 2'h0}, '{1'b0, 8'h04, 32'h0, 2'h0},
    '{1'b0, 8'h08, 32'h0, 2'h0}, '{1'b0, 8'h0c, 32'h0, 2'h0}, '{1'b0, 8'h10, 32'h0, 2'h0},
    '{1'b1, 8'h04, 32'hffab_cdef, 2'h0}, '{1'b0, 8'h04, 32'h00ab_cdef, 2'h0},
    '{1'b0, 8'h14, 32'h0, 2'h2}, '{1'b1, 8'h14, 32'h1, 2'h2}, '{1'b1, 8'h04, 32'h5, 2'h0},
    '{1'b1, 8'h10, 32'h1, 2'h0}, '{1'b0, 8'h10, 32'h1, 2'h0}};

  stk_top uut (.aclk(aclk), .aresetn(aresetn), .debug_halt(halt),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bred),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rred),
    .irq(irq), .tick_pulse(tick));

  always #4 aclk = ~aclk;

  task end_of_test;
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // The whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_of_test;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bred <= 1'b1;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!(bv && bred));
    bred <= 1'b0;
    chk({30'h0, br}, {30'h0, er});
  endtask : wr_reg

  task rd_reg(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rred <= 1'b1;
    do begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
    end while (!(rv && rred));
    rred <= 1'b0;
    d = rd;
    chk({30'h0, rr}, {30'h0, er});
  endtask : rd_reg

  task rchk(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a, 2'h0, v1);
    chk(v1, e);
  endtask : rchk

  // Irq is a flop behind the status and mask registers, so let it settle
  task irq_is(input logic e);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : irq_is

  // Leaves n at the cycles waited, or 100 when no tick came
  task wait_tick;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!tick && n < 100);
  endtask : wait_tick

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr_reg(rows[i].a, rows[i].d, rows[i].r);
      else begin
        rd_reg(rows[i].a, rows[i].r, v1);
        chk(v1, rows[i].d);
      end
    end
    wr_reg(8'h00, 32'h1, 2'h0);
    wait_tick;
    wait_tick;
    chk(32'(n), 32'h6);
    irq_is(1'b1);
    halt <= 1'b1;
    rd_reg(8'h08, 2'h0, v2);
    rd_reg(8'h08, 2'h0, v1);
    chk(v1, v2);
    halt <= 1'b0;
    wait_tick;
    wr_reg(8'h00, 32'h0, 2'h0);
    rchk(8'h00, 32'h0001_0004);
    rchk(8'h00, 32'h0000_0004);
    rchk(8'h0c, 32'h1);
    wr_reg(8'h10, 32'h0, 2'h0);
    irq_is(1'b0);
    wr_reg(8'h10, 32'h1, 2'h0);
    irq_is(1'b1);
    wr_reg(8'h0c, 32'h1, 2'h0);
    irq_is(1'b0);
    rchk(8'h0c, 32'h0);
    wr_reg(8'h00, 32'h1, 2'h0);
    wait_tick;
    wr_reg(8'h00, 32'h0, 2'h0);
    wr_reg(8'h0c, 32'h1, 2'h0);
    wr_reg(8'h08, 32'hffff_ffff, 2'h0);
    rchk(8'h08, 32'h0);
    rchk(8'h00, 32'h4);
    rchk(8'h0c, 32'h0);
    // The descent in progress still ends with one tick, then the counter parks at zero
    wr_reg(8'h00, 32'h1, 2'h0);
    wr_reg(8'h04, 32'h0, 2'h0);
    wait_tick;
    wait_tick;
    chk(32'(n), 32'h64);
    rchk(8'h08, 32'h0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h10, 32'h0);
    rchk(8'h00, 32'h4);
    end_of_test;
  end
endmodule : stk_top_tb
